/* File: emb_params.svh */
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH

// ====================================================================
// widths of the external bus
`define EMB_ADDR_W 16
`define EMB_DATA_W 16

// ====================================================================
// reset values of the pin function selects, port directions and port outputs: all pins on the bus
`define EMB_SEL_RST 16'hFFFF
`define EMB_DIR_RST 16'h0000
`define EMB_OUT_RST 16'h0000

// ====================================================================
// strobe low time in clock cycles, default
`define EMB_WAIT_DEF 1
`define EMB_CNT_W 4

`endif

/* File: emb_pkg.sv */
`include "emb_params.svh"

package emb_pkg;

    // ================================================================
    // bus sequencer states
    typedef enum logic [1:0] {
        EMB_IDLE   = 2'b00,
        EMB_SETUP  = 2'b01,
        EMB_STROBE = 2'b10,
        EMB_HOLD   = 2'b11
    } emb_state_type;

    // ================================================================
    // one core-side access request
    typedef struct packed {
        logic write;                      // 1 write, 0 read
        logic prog;                       // 1 program space, 0 data space
        logic [`EMB_ADDR_W-1:0] addr;     // word address
        logic [`EMB_DATA_W-1:0] wdata;    // write data
    } emb_req_type;

    // ================================================================
    // software pin configuration, written as one word
    typedef struct packed {
        logic [`EMB_ADDR_W-1:0] a_bus_sel; // 1 address bus, 0 port a
        logic [`EMB_ADDR_W-1:0] a_dir;     // port a, 1 output
        logic [`EMB_ADDR_W-1:0] a_out;     // port a output values
        logic [`EMB_DATA_W-1:0] g_bus_sel; // 1 data bus, 0 port g
        logic [`EMB_DATA_W-1:0] g_dir;     // port g, 1 output
        logic [`EMB_DATA_W-1:0] g_out;     // port g output values
        logic ps_as_cs0;                   // program select pin shows cs 0
        logic ds_as_cs1;                   // data select pin shows cs 1
    } emb_cfg_type;

endpackage

/* File: emb_pin_mux.sv */
`include "emb_params.svh"

module emb_pin_mux
    import emb_pkg::*;
#(
    parameter int W = `EMB_DATA_W
) (
    // clock, reset and enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // function select and sources
    input wire logic [W-1:0] bus_sel,
    input wire logic [W-1:0] bus_out,
    input wire logic [W-1:0] bus_oe,
    input wire logic [W-1:0] gpio_dir,
    input wire logic [W-1:0] gpio_out,
    // pin side
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe,
    // general-purpose input view
    output logic [W-1:0] gpio_in
);

    // ================================================================
    // per-pin selection between bus and general-purpose function
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            // RULE_04 per-pin direction select
            // RULE_05 per-pin direction select
            assign pin_o[i] = bus_sel[i] ? bus_out[i] : gpio_out[i];
            assign pin_oe[i] = bus_sel[i] ? bus_oe[i] : gpio_dir[i];
        end
    endgenerate

    // ================================================================
    // registered input sample for the port view
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_in <= '0;
        end else if (ce) begin
            gpio_in <= pin_i;
        end
    end

endmodule

/* File: emb_bus_ctrl.sv */
// Function
// RULE_01 - address pins carry every external access address
// RULE_02 - data pins carry every external access word
// RULE_03 - data pins float when bus idle
// RULE_04 - address pins usable as port a gpio
// RULE_05 - data pins usable as port g gpio
// RULE_06 - bus function selected after reset
// RULE_07 - program select low during program accesses
// RULE_08 - program select reprogrammable as chip select zero
// RULE_09 - data select low, reprogrammable chip select one
// RULE_10 - read strobe low, capture on rise
// RULE_11 - write strobe low, data driven out
// RULE_12 - per-pin bus or gpio select, bus reset
`include "emb_params.svh"

module emb_bus_ctrl
    import emb_pkg::*;
#(
    parameter int WAIT_CYC = `EMB_WAIT_DEF
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // core access request
    input wire logic req_valid,
    input wire emb_req_type req,
    output logic req_ready,
    // read answer
    output logic rd_valid,
    output logic [`EMB_DATA_W-1:0] rd_data,
    // pin configuration write
    input wire logic cfg_we,
    input wire emb_cfg_type cfg_wdata,
    output emb_cfg_type cfg_q,
    // chip select unit levels, active low
    input wire logic chip_select_zero_n,
    input wire logic chip_select_one_n,
    // general-purpose port views
    output logic [`EMB_ADDR_W-1:0] port_a_general_io,
    output logic [`EMB_DATA_W-1:0] port_g_general_io,
    // address pins
    input wire logic [`EMB_ADDR_W-1:0] ext_address_lines_i,
    output logic [`EMB_ADDR_W-1:0] ext_address_lines_o,
    output logic [`EMB_ADDR_W-1:0] ext_address_lines_oe,
    // data pins
    input wire logic [`EMB_DATA_W-1:0] ext_data_lines_i,
    output logic [`EMB_DATA_W-1:0] ext_data_lines_o,
    output logic [`EMB_DATA_W-1:0] ext_data_lines_oe,
    // bus control pins
    output logic program_space_select_n,
    output logic data_space_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n
);

    // ================================================================
    // state
    emb_state_type state_ff, nxt_state;       // sequencer
    emb_req_type req_ff;                      // access in flight
    logic [`EMB_CNT_W-1:0] cnt_ff, nxt_cnt;   // strobe cycles left
    logic [`EMB_DATA_W-1:0] rdata_ff;         // captured read word
    logic rvalid_ff;                          // read answer pulse
    emb_cfg_type cfg_ff;                      // pin configuration

    localparam logic [`EMB_CNT_W-1:0] STRB_LAST = `EMB_CNT_W'(WAIT_CYC - 1);

    // ================================================================
    // decoded phases
    wire take = req_valid && req_ready && ce;
    wire active = (state_ff != EMB_IDLE);
    wire in_strobe = (state_ff == EMB_STROBE);
    wire strobe_end = in_strobe && (cnt_ff == '0);
    wire bus_rd_low = in_strobe && !req_ff.write;
    wire bus_wr_low = in_strobe && req_ff.write;
    wire ps_bus_n = !(active && req_ff.prog);
    wire ds_bus_n = !(active && !req_ff.prog);

    assign req_ready = (state_ff == EMB_IDLE);

    // ================================================================
    // next-state logic of the access sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            EMB_IDLE: begin
                if (take) begin
                    nxt_state = EMB_SETUP;
                end
            end
            EMB_SETUP: begin
                // address and select settle before the strobe
                nxt_state = EMB_STROBE;
                nxt_cnt = STRB_LAST;
            end
            EMB_STROBE: begin
                if (cnt_ff == '0) begin
                    nxt_state = EMB_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            EMB_HOLD: begin
                // strobe high, address and select still held
                nxt_state = EMB_IDLE;
            end
            default: begin
                nxt_state = EMB_IDLE;
            end
        endcase
    end

    // ================================================================
    // sequencer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= EMB_IDLE;
            cnt_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ================================================================
    // request capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_ff <= '0;
        end else if (take) begin
            req_ff <= req;
        end
    end

    // ================================================================
    // read data capture as the read strobe returns high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end else if (ce) begin
            // RULE_10 capture on rise
            rvalid_ff <= strobe_end && !req_ff.write;
            if (strobe_end && !req_ff.write) begin
                rdata_ff <= ext_data_lines_i;
            end
        end
    end

    assign rd_valid = rvalid_ff;
    assign rd_data = rdata_ff;

    // ================================================================
    // pin configuration, bus function out of reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // RULE_06 bus after reset
            // RULE_12 bus select reset
            cfg_ff.a_bus_sel <= `EMB_SEL_RST;
            cfg_ff.g_bus_sel <= `EMB_SEL_RST;
            cfg_ff.a_dir <= `EMB_DIR_RST;
            cfg_ff.g_dir <= `EMB_DIR_RST;
            cfg_ff.a_out <= `EMB_OUT_RST;
            cfg_ff.g_out <= `EMB_OUT_RST;
            cfg_ff.ps_as_cs0 <= 1'b0;
            cfg_ff.ds_as_cs1 <= 1'b0;
        end else if (ce && cfg_we) begin
            cfg_ff <= cfg_wdata;
        end
    end

    assign cfg_q = cfg_ff;

    // ================================================================
    // control pins
    // RULE_07 program select strobe
    // RULE_08 chip select zero option
    assign program_space_select_n = cfg_ff.ps_as_cs0 ? chip_select_zero_n : ps_bus_n;
    // RULE_09 data select or cs one
    assign data_space_select_n = cfg_ff.ds_as_cs1 ? chip_select_one_n : ds_bus_n;
    assign read_strobe_n = !bus_rd_low;
    // RULE_11 write strobe low
    assign write_strobe_n = !bus_wr_low;

    // ================================================================
    // address pin group: bus outputs always driven
    // RULE_01 address on pins
    emb_pin_mux #(.W(`EMB_ADDR_W)) u_addr_mux (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .bus_sel(cfg_ff.a_bus_sel),
        .bus_out(req_ff.addr),
        .bus_oe({`EMB_ADDR_W{1'b1}}),
        .gpio_dir(cfg_ff.a_dir),
        .gpio_out(cfg_ff.a_out),
        .pin_i(ext_address_lines_i),
        .pin_o(ext_address_lines_o),
        .pin_oe(ext_address_lines_oe),
        .gpio_in(port_a_general_io)
    );

    // ================================================================
    // data pin group: bus outputs driven only while write strobe is low
    // RULE_02 data word on pins
    // RULE_03 float when idle
    emb_pin_mux #(.W(`EMB_DATA_W)) u_data_mux (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .bus_sel(cfg_ff.g_bus_sel),
        .bus_out(req_ff.wdata),
        .bus_oe({`EMB_DATA_W{bus_wr_low}}),
        .gpio_dir(cfg_ff.g_dir),
        .gpio_out(cfg_ff.g_out),
        .pin_i(ext_data_lines_i),
        .pin_o(ext_data_lines_o),
        .pin_oe(ext_data_lines_oe),
        .gpio_in(port_g_general_io)
    );

    // ================================================================
    // assertions
    a_addr_on_pins: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
        active |-> ((ext_address_lines_o ^ req_ff.addr) & cfg_ff.a_bus_sel) == '0)
        else $error("address pins differ from access address");

    a_write_data_out: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
        !write_strobe_n |-> (ext_data_lines_oe & cfg_ff.g_bus_sel) == cfg_ff.g_bus_sel
            && ((ext_data_lines_o ^ req_ff.wdata) & cfg_ff.g_bus_sel) == '0)
        else $error("write data not driven during write strobe");

    a_idle_data_float: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
        !active |-> (ext_data_lines_oe & cfg_ff.g_bus_sel) == '0)
        else $error("data bus driven while idle");

    a_reset_bus_sel: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
        !$past(rst_n) |-> cfg_ff.a_bus_sel == `EMB_SEL_RST
            && cfg_ff.g_bus_sel == `EMB_SEL_RST)
        else $error("pins not on bus after reset");

    a_prog_select: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
        !cfg_ff.ps_as_cs0 |-> program_space_select_n == !(active && req_ff.prog))
        else $error("program select wrong");

    a_cs0_pass: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
        cfg_ff.ps_as_cs0 |-> program_space_select_n == chip_select_zero_n)
        else $error("chip select zero not passed");

    a_data_select: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
        !cfg_ff.ds_as_cs1 && take && !req.prog |=> !data_space_select_n [*3])
        else $error("data select not low through access");

    a_read_capture: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
        ce && !read_strobe_n && strobe_end |=> rd_valid && read_strobe_n
            && rd_data == $past(ext_data_lines_i))
        else $error("read data not captured at strobe rise");

    a_write_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
        take && req.write |=> write_strobe_n ##1 !write_strobe_n)
        else $error("write strobe not low after setup");

    a_gpio_dir: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
        ((ext_address_lines_oe ^ cfg_ff.a_dir) & ~cfg_ff.a_bus_sel) == '0)
        else $error("port a direction not followed");

endmodule

/* File: emb_mem_model.sv */
// ====================================================================
// external static memory: program and data halves
module emb_mem_model #(
    parameter int RD_DLY = 2
) (
    // bus pins seen by the memory
    input wire logic [15:0] addr,
    input wire logic [15:0] din,
    input wire logic ps_n,
    input wire logic ds_n,
    input wire logic rd_n,
    input wire logic wr_n,
    // memory output drive
    output logic [15:0] dout,
    output logic doe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pm [256]; // program half
    logic [15:0] dm [256]; // data half
    logic [15:0] wlat; // write word held while strobe low
    // follow data while write strobe low
    always @(din or wr_n) begin
        if (!wr_n) begin
            wlat = din;
        end
    end
    always @(posedge wr_n) begin
        if (!ps_n) begin
            pm[addr[7:0]] <= wlat;
        end
        if (!ds_n) begin
            dm[addr[7:0]] <= wlat;
        end
    end
    // drive only while read strobe and select low
    assign #RD_DLY doe = !rd_n && (!ps_n || !ds_n);
    assign #RD_DLY dout = !ps_n ? pm[addr[7:0]] : dm[addr[7:0]];
endmodule

/* File: emb_testbench.sv */
`include "emb_params.svh"

// ====================================================================
// bench top
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
    logic mclk = 0;
    logic rst_n = 0;
    localparam int WAITS = 2; // strobe low cycles of the block under test
    logic ce = 1; // clock enable of the block
    logic req_valid = 0;
    emb_req_type req = '0;
    logic cfg_we = 0;
    emb_cfg_type cfg_wdata = '0;
    logic cs0_n = 1; // chip select unit levels
    logic cs1_n = 1;
    logic [15:0] a_ext = 16'hFFFF; // outside drive on address pins
    logic [15:0] g_ext = 16'hFFFF; // pull-up or outside drive on data pins
    logic req_ready, rd_valid, ps_n, ds_n, rd_n, wr_n, m_oe;
    logic [15:0] rd_data, pa, pg, a_o, a_oe, d_o, d_oe, m_d;
    emb_cfg_type cfg_q;
    wire [15:0] a_wire;
    wire [15:0] d_wire;
    int fail_count = 0;
    int samples_checked = 0;
    // ================================================================
    // pin resolution, small hold delay on the wires
    assign #1 a_wire = (a_oe & a_o) | (~a_oe & a_ext);
    assign #1 d_wire = (d_oe & d_o) | (~d_oe & (m_oe ? m_d : g_ext));
    initial begin
        forever #4 mclk = ~mclk;
    end
    emb_bus_ctrl #(.WAIT_CYC(WAITS)) dut (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_q(cfg_q),
        .chip_select_zero_n(cs0_n), .chip_select_one_n(cs1_n),
        .port_a_general_io(pa), .port_g_general_io(pg),
        .ext_address_lines_i(a_wire), .ext_address_lines_o(a_o),
        .ext_address_lines_oe(a_oe),
        .ext_data_lines_i(d_wire), .ext_data_lines_o(d_o), .ext_data_lines_oe(d_oe),
        .program_space_select_n(ps_n), .data_space_select_n(ds_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n));
    emb_mem_model mem (
        .addr(a_wire), .din(d_wire), .ps_n(ps_n), .ds_n(ds_n),
        .rd_n(rd_n), .wr_n(wr_n), .dout(m_d), .doe(m_oe));
    // ================================================================
    // one access, pins watched every cycle
    task automatic access(input logic wr, input logic sp, input logic [15:0] a,
                          input logic [15:0] wd);
        logic seen;
        logic act;
        logic strb;
        seen = 0;
        @(posedge mclk);
        req_valid <= 1;
        req <= '{wr, sp, a, wd};
        @(posedge mclk);
        req_valid <= 0;
        // n counts cycles after the take edge: setup, strobes, hold, idle
        for (int n = 0; n <= WAITS + 2; n++) begin
            @(negedge mclk);
            act = (n <= WAITS + 1);
            strb = (n >= 1 && n <= WAITS);
            `CHK("data oe", ((strb && wr) ? 16'hFFFF : 16'h0000), d_oe)
            `CHK("read strobe", !(strb && !wr), rd_n)
            `CHK("write strobe", !(strb && wr), wr_n)
            `CHK("ready", !act, req_ready)
            `CHK("prog select", !(act && sp), ps_n)
            `CHK("data select", !(act && !sp), ds_n)
            if (act) begin
                `CHK("address", a, a_o)
            end
            if (strb && wr) begin
                `CHK("write word", wd, d_o)
            end
            `CHK("read valid", (!wr && n == WAITS + 1), rd_valid)
            if (rd_valid) begin
                seen = 1;
                `CHK("read word", wd, rd_data)
            end
        end
        `CHK("read answer", !wr, seen)
    endtask
    // ================================================================
    // reset state of pins and configuration
    task automatic t_reset();
        `CHK("cfg", emb_cfg_type'({16'hFFFF, 32'h0, 16'hFFFF, 34'h0}), cfg_q)
        `CHK("addr oe", 16'hFFFF, a_oe)
        `CHK("idle data oe", 16'h0000, d_oe)
        `CHK("idle selects", 2'b11, {ps_n, ds_n})
    endtask
    // program and data space kept apart, back to back
    task automatic t_spaces();
        access(1, 1, 16'h1234, 16'hBEEF);
        access(1, 0, 16'h0034, 16'h4321);
        access(0, 1, 16'h1234, 16'hBEEF);
        access(0, 0, 16'h0034, 16'h4321);
    endtask
    // per-pin gpio function on address pins, whole data pin group as port g
    task automatic t_gpio();
        @(posedge mclk);
        cfg_we <= 1;
        cfg_wdata <= '{16'hFF00, 16'h000F, 16'h0005, 16'h0000, 16'hFF00, 16'h3C00, 1'b0, 1'b0};
        a_ext <= 16'h00A0;
        g_ext <= 16'h00C3;
        @(posedge mclk);
        cfg_we <= 0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK("addr oe mix", 16'hFF0F, a_oe)
        `CHK("port a out", 16'h0005, a_o & 16'h000F)
        `CHK("port a in", 16'h00A5, pa & 16'h00FF)
        `CHK("data oe gpio", 16'hFF00, d_oe)
        `CHK("port g in", 16'h3CC3, pg)
        @(posedge mclk);
        cfg_we <= 1;
        cfg_wdata <= emb_cfg_type'({16'hFFFF, 32'h0, 16'hFFFF, 34'h0});
        @(posedge mclk);
        cfg_we <= 0;
        g_ext <= 16'hFFFF;
    endtask
    // clock enable low in mid-read freezes the sequence
    task automatic t_freeze();
        @(posedge mclk);
        req_valid <= 1;
        req <= '{1'b0, 1'b0, 16'h0034, 16'h0000};
        @(posedge mclk);
        req_valid <= 0;
        @(posedge mclk);
        ce <= 0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK("frozen strobe", 1'b0, rd_n)
        `CHK("frozen select", 1'b0, ds_n)
        `CHK("frozen answer", 1'b0, rd_valid | req_ready)
        @(posedge mclk);
        ce <= 1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `CHK("thawed answer", 1'b1, rd_valid)
        `CHK("thawed word", 16'h4321, rd_data)
        @(posedge mclk);
        @(negedge mclk);
        `CHK("thawed idle", 2'b10, {req_ready, rd_valid})
    endtask
    // select pins reprogrammed as chip selects
    task automatic t_cs();
        @(posedge mclk);
        cfg_we <= 1;
        cfg_wdata <= emb_cfg_type'({16'hFFFF, 32'h0, 16'hFFFF, 32'h0, 2'b11});
        cs0_n <= 0;
        @(posedge mclk);
        cfg_we <= 0;
        @(negedge mclk);
        `CHK("cs zero", 2'b01, {ps_n, ds_n})
        @(posedge mclk);
        cs0_n <= 1;
        cs1_n <= 0;
        @(negedge mclk);
        `CHK("cs one", 2'b10, {ps_n, ds_n})
    endtask
    // ================================================================
    // verdict
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        results();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        @(negedge mclk);
        t_reset();
        t_spaces();
        t_freeze();
        t_gpio();
        t_cs();
        results();
    end
endmodule
